// [rtl/reconfig_status_recorder.sv]
// Purpose: records reconfiguration cause, current-state view and two history records
// Assumes: trigger strobes and mode inputs come from logic on ref_clk (10 MHz)
// Notes:   read only; user logic sees the words through a shift capture, the cause word also on cause_q
// How it works
// - cause of last reconfiguration is recorded
// - factory view: state, zero pad, boot address
// - app1 view: state, watchdog enable, timeout
// - app1 layout ignores scheme select pins
// - app2 view uses the factory layout
// - two previous-state records kept for debug
// - record one: 31 bits, one-hot source 30:26
// - simultaneous sources: highest order bit only
// - bits 25:24 hold state at leaving
// - bits 23:0 hold that load's boot address
// - status on oscillator, shifting on shift clock
// - capture copies status into shift register
// - status updated before factory load begins
// - record two: same layout, one step older
`timescale 1ns/100ps
`include "recorder_params.svh"

module reconfig_status_recorder
  import recorder_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   srst,
  input  wire evt_s                   trigger,
  input  wire msm_e                   msm_state,
  input  wire logic [`RSR_BOOT_W-1:0] boot_addr,
  input  wire logic                   wd_enable,
  input  wire logic [`RSR_WDT_W-1:0]  wd_timeout,
  input  wire logic                   upgrade_shift_clock,
  input  wire logic                   capture_pin,
  input  wire logic [1:0]             capture_sel,
  input  wire logic                   shift_data_in,
  output      logic                   shift_data_out,
  output      logic [`RSR_SRC_W-1:0]  cause_q,
  output      logic                   record_done
);

  prev_rec_s              prev1_q;
  prev_rec_s              prev2_q;
  logic                   prev1_valid_q;
  logic                   prev2_valid_q;
  logic [`RSR_VIEW_W-1:0] view_q;
  logic [`RSR_SRC_W-1:0]  src_onehot;
  logic                   any_evt;
  logic                   in_app;
  shift_pins_s            pins_raw;

  // keep only the highest order source when several arrive together
  function automatic logic [`RSR_SRC_W-1:0] pick_source(input evt_s e);
    logic [`RSR_SRC_W-1:0] v;
    v = '0;
    if (e.ext_reset)          v[`RSR_SRC_EXT_RST] = 1'b1;
    else if (e.crc_error)     v[`RSR_SRC_CRC]     = 1'b1;
    else if (e.error_pin)     v[`RSR_SRC_ERR_PIN] = 1'b1;
    else if (e.wdog_timeout)  v[`RSR_SRC_WDOG]    = 1'b1;
    else if (e.logic_request) v[`RSR_SRC_LOGIC]   = 1'b1;
    return v;
  endfunction

  // build the 32-bit current-state view for a given mode
  function automatic logic [`RSR_VIEW_W-1:0] build_view(input msm_e m,
                                                        input logic [`RSR_BOOT_W-1:0] ba,
                                                        input logic we,
                                                        input logic [`RSR_WDT_W-1:0] wt);
    logic [`RSR_VIEW_W-1:0] v;
    v = '0;
    v[`RSR_MSM_HI:`RSR_MSM_LO] = m;
    if (m == MSM_APP1)
    begin
      v[`RSR_WDEN_BIT]         = we;
      v[`RSR_WDT_W-1:0]        = wt;
    end
    else
      v[`RSR_BOOT_W-1:0]       = ba;
    return v;
  endfunction

  assign src_onehot = pick_source(trigger);
  assign any_evt    = |trigger;
  assign in_app     = (msm_state == MSM_APP1) || (msm_state == MSM_APP2);

  // raw pin bundle; the shifter does its own three-flop sampling
  assign pins_raw = {upgrade_shift_clock, capture_pin, capture_sel, shift_data_in};

  // view registered on the oscillator clock; scheme pins never enter it
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      view_q <= '0;
    else
      view_q <= build_view(msm_state, boot_addr, wd_enable, wd_timeout);
  end

  // cause is written in the trigger cycle, ahead of any factory reload
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      cause_q <= `RSR_CAUSE_RESET;
    else if (any_evt)
      cause_q <= src_onehot;
  end

  // one-cycle pulse tells the sequencer the status is settled
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      record_done <= 1'b0;
    else
      record_done <= any_evt;
  end

  // history only follows leaving an application configuration
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      prev1_q       <= `RSR_REC_RESET;
      prev2_q       <= `RSR_REC_RESET;
      prev1_valid_q <= 1'b0;
      prev2_valid_q <= 1'b0;
    end
    else if (any_evt && in_app)
    begin
      prev2_q       <= prev1_q;
      prev2_valid_q <= prev1_valid_q;
      prev1_q       <= '{source: src_onehot, msm: msm_state, boot: boot_addr};
      prev1_valid_q <= 1'b1;
    end
  end

  // shift port; no write path reaches the status words
  capture_shifter u_shift
  (
    .ref_clk        (ref_clk),
    .srst           (srst),
    .pins           (pins_raw),
    .view_word      (view_q),
    .prev1_word     (prev1_q),
    .prev2_word     (prev2_q),
    .cause_word     (cause_q),
    .prev1_valid    (prev1_valid_q),
    .prev2_valid    (prev2_valid_q),
    .shift_data_out (shift_data_out)
  );

  // checks next to the recording logic
  a_cause_onehot: assert property (@(posedge ref_clk) disable iff (srst)
    any_evt |=> $onehot(cause_q))
    else $error("cause not one-hot after trigger");

  a_ext_wins: assert property (@(posedge ref_clk) disable iff (srst)
    (trigger.ext_reset && trigger.logic_request) |=> cause_q == 5'h10)
    else $error("external reset did not win");

  a_factory_view: assert property (@(posedge ref_clk) disable iff (srst)
    msm_state == MSM_FACTORY |=>
      view_q == {2'($past(msm_state)), 6'h00, $past(boot_addr)})
    else $error("factory view layout wrong");

  a_app1_view: assert property (@(posedge ref_clk) disable iff (srst)
    msm_state == MSM_APP1 |=>
      view_q == {2'($past(msm_state)), $past(wd_enable), $past(wd_timeout)})
    else $error("app1 view layout wrong");

  a_app2_view: assert property (@(posedge ref_clk) disable iff (srst)
    msm_state == MSM_APP2 |=> view_q[29:24] == 6'h00 && view_q[23:0] == $past(boot_addr))
    else $error("app2 view layout wrong");

  a_history_shift: assert property (@(posedge ref_clk) disable iff (srst)
    (any_evt && in_app) |=> prev2_q == $past(prev1_q) && prev1_valid_q)
    else $error("history not shifted");

  a_prev1_fields: assert property (@(posedge ref_clk) disable iff (srst)
    (any_evt && in_app) |=> prev1_q.msm == $past(msm_state)
      && prev1_q.boot == $past(boot_addr) && prev1_q.source == cause_q)
    else $error("record one fields wrong");

  a_record_done: assert property (@(posedge ref_clk) disable iff (srst)
    any_evt |=> record_done ##1 (record_done == $past(any_evt)))
    else $error("record done missing");

  a_factory_keep: assert property (@(posedge ref_clk) disable iff (srst)
    (any_evt && msm_state == MSM_FACTORY) |=> $stable(prev1_q) && $stable(prev2_q))
    else $error("history changed in factory");

  // hold-time and priority checks between triggers
  a_cause_hold: assert property (@(posedge ref_clk) disable iff (srst)
    !any_evt |=> $stable(cause_q))
    else $error("cause changed without trigger");

  a_done_idle: assert property (@(posedge ref_clk) disable iff (srst)
    !any_evt |=> !record_done)
    else $error("record done without trigger");

  a_crc_wins: assert property (@(posedge ref_clk) disable iff (srst)
    (trigger.crc_error && !trigger.ext_reset) |=> cause_q == 5'h08)
    else $error("checksum source did not win");

  a_logic_loses: assert property (@(posedge ref_clk) disable iff (srst)
    (trigger.logic_request && (trigger != 5'h01)) |=> !cause_q[0])
    else $error("logic request beat a higher source");

  // a valid record always carries exactly one source bit
  a_rec_onehot: assert property (@(posedge ref_clk) disable iff (srst)
    prev1_valid_q |-> $onehot(prev1_q.source))
    else $error("record one source not one-hot");

  a_rec_two_valid: assert property (@(posedge ref_clk) disable iff (srst)
    prev2_valid_q |-> prev1_valid_q && $onehot(prev2_q.source))
    else $error("record two invalid layout");

  a_history_hold: assert property (@(posedge ref_clk) disable iff (srst)
    !(any_evt && in_app) |=> $stable(prev1_q) && $stable(prev2_q))
    else $error("history changed without an exit");

  // reset clears cause_q, record_done and both valid flags; deliberately not disabled by reset
  a_reset_clear: assert property (@(posedge ref_clk)
    srst |=> cause_q == 5'h00 && !record_done && !prev1_valid_q && !prev2_valid_q)
    else $error("reset left recorded state");

endmodule

// [rtl/recorder_params.svh]
// Purpose: offsets, field positions, reset values and counts for the status recorder
// Assumes: included by bare name from rtl files
// Notes:   field positions index the 32-bit view and the 31-bit history records
`ifndef RECORDER_PARAMS_SVH
`define RECORDER_PARAMS_SVH

`define RSR_VIEW_W        32
`define RSR_REC_W         31
`define RSR_BOOT_W        24
`define RSR_WDT_W         29
`define RSR_SRC_W         5
`define RSR_MSM_HI        31
`define RSR_MSM_LO        30
`define RSR_PAD_HI        29
`define RSR_PAD_LO        24
`define RSR_WDEN_BIT      29
`define RSR_REC_MSM_HI    25
`define RSR_REC_MSM_LO    24
`define RSR_SRC_EXT_RST   4
`define RSR_SRC_CRC       3
`define RSR_SRC_ERR_PIN   2
`define RSR_SRC_WDOG      1
`define RSR_SRC_LOGIC     0
`define RSR_SYNC_STAGES   3
`define RSR_REC_RESET     31'h00000000
`define RSR_CAUSE_RESET   5'h00
`define RSR_BAD_CAPTURE   32'hFFFFFFFF

`endif

// [rtl/recorder_pkg.sv]
// Purpose: shared types of the reconfiguration status recorder
// Assumes: recorder_params.svh gives widths
// Notes:   history record is packed in the printed bit order
`include "recorder_params.svh"

package recorder_pkg;

  // master state machine mode, encoding goes out in view bits 31:30
  typedef enum logic [1:0] {MSM_FACTORY, MSM_APP1, MSM_APP2} msm_e;

  // which word a capture copies into the shift register
  typedef enum logic [1:0] {CAP_VIEW, CAP_PREV1, CAP_PREV2, CAP_CAUSE} capsel_e;

  // reconfiguration triggers, one-cycle strobes on ref_clk
  typedef struct packed {
    logic ext_reset;
    logic crc_error;
    logic error_pin;
    logic wdog_timeout;
    logic logic_request;
  } evt_s;

  // one history record, 31 bits
  typedef struct packed {
    logic [`RSR_SRC_W-1:0]  source;
    logic [1:0]             msm;
    logic [`RSR_BOOT_W-1:0] boot;
  } prev_rec_s;

  // raw pins of the upgrade shift port
  typedef struct packed {
    logic       shift_clk;
    logic       capture;
    logic [1:0] sel;
    logic       data_in;
  } shift_pins_s;

endpackage

// [rtl/capture_shifter.sv]
// Purpose: upgrade shift register, clocked by edges of the sampled shift clock pin
// Assumes: pins are asynchronous to ref_clk; shift clock well below ref_clk/4
// Notes:   shifts lsb first, serial input enters at bit 31
`timescale 1ns/100ps
`include "recorder_params.svh"

module capture_shifter
  import recorder_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   srst,
  input  wire shift_pins_s            pins,
  input  wire logic [`RSR_VIEW_W-1:0] view_word,
  input  wire logic [`RSR_REC_W-1:0]  prev1_word,
  input  wire logic [`RSR_REC_W-1:0]  prev2_word,
  input  wire logic [`RSR_SRC_W-1:0]  cause_word,
  input  wire logic                   prev1_valid,
  input  wire logic                   prev2_valid,
  output      logic                   shift_data_out
);

  localparam int PW = $bits(shift_pins_s);

  logic [PW-1:0]          s1_q;
  logic [PW-1:0]          s2_q;
  logic [PW-1:0]          s3_q;
  shift_pins_s            stable_q;
  logic [`RSR_VIEW_W-1:0] shreg_q;
  logic                   clk_prev_q;
  logic                   shift_edge;
  logic [`RSR_VIEW_W-1:0] load_word;

  // three-stage sampling; a bit changes once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < PW; g++)
    begin : g_sync
      always_ff @(posedge ref_clk)
      begin
        if (srst)
        begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
        end
        else
        begin
          s1_q[g] <= pins[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
        end
      end
    end
  endgenerate

  // filtered pin values, held while stages disagree
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      stable_q <= '0;
    else
      stable_q <= shift_pins_s'((s2_q & s3_q) | (stable_q & (s2_q | s3_q)));
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      clk_prev_q <= 1'b0;
    else
      clk_prev_q <= stable_q.shift_clk;
  end

  assign shift_edge = stable_q.shift_clk & ~clk_prev_q;

  // word chosen for capture; an early history capture returns the marker
  always_comb
  begin
    load_word = `RSR_BAD_CAPTURE;
    case (capsel_e'(stable_q.sel))
      CAP_VIEW:  load_word = view_word;
      CAP_PREV1: if (prev1_valid) load_word = {1'b0, prev1_word};
      CAP_PREV2: if (prev2_valid) load_word = {1'b0, prev2_word};
      default:   load_word = {{(`RSR_VIEW_W-`RSR_SRC_W){1'b0}}, cause_word};
    endcase
  end

  // capture copies status in, otherwise each edge shifts one bit out
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      shreg_q <= '0;
    else if (shift_edge && stable_q.capture)
      shreg_q <= load_word;
    else if (shift_edge)
      shreg_q <= {stable_q.data_in, shreg_q[`RSR_VIEW_W-1:1]};
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      shift_data_out <= 1'b0;
    else
      shift_data_out <= shreg_q[0];
  end

endmodule

// [bench/shift_reader.sv]
// Purpose: user logic reading the status words through the upgrade shift port
// Assumes: ref_clk at 10 MHz; pins are slow against it
// Notes:   shift clock stands low between frames
`timescale 1ns/100ps

module shift_reader
(
  input  wire logic       ref_clk,
  input  wire logic       shift_data_out,
  output      logic       shift_clk,
  output      logic       capture,
  output      logic [1:0] sel,
  output      logic       data_in
);
  // idle pins at time zero
  initial
  begin
    shift_clk = 1'b0;
    capture   = 1'b0;
    sel       = 2'h0;
    data_in   = 1'b0;
  end

  // one slow clock pulse; 8 cycles a phase clears the 3-flop sampler
  task automatic pulse();
    repeat (8) @(posedge ref_clk);
    #10 shift_clk = 1'b1;
    repeat (8) @(posedge ref_clk);
    #10 shift_clk = 1'b0;
  endtask

  // capture rise, then 31 shift rises, lsb first
  task automatic read_word(input logic [1:0] s, output logic [31:0] w);
    @(posedge ref_clk);
    #10 sel = s;
    capture = 1'b1;
    for (int i = 0; i < 32; i++)
    begin
      pulse();
      repeat (8) @(posedge ref_clk);
      #10 w[i] = shift_data_out;
      capture = 1'b0;
      data_in = ~data_in; // toggles so a leak into status would show
    end
  endtask
endmodule

// [bench/reconfig_status_recorder_tb_top.sv]
// Purpose: self-checking bench of the reconfiguration status recorder
// Assumes: 10 MHz ref_clk; shift_reader plays the user logic
// Notes:   each scenario task judges its own results
`timescale 1ns/100ps

module reconfig_status_recorder_tb_top
  import recorder_pkg::*;
();
  logic        ref_clk;
  logic        srst;
  evt_s        trigger;
  msm_e        msm_state;
  logic [23:0] boot_addr;
  logic        wd_enable;
  logic [28:0] wd_timeout;
  logic        shift_clk;
  logic        capture;
  logic [1:0]  sel;
  logic        data_in;
  logic        shift_data_out;
  logic [4:0]  cause_q;
  logic        record_done;
  logic [31:0] w;
  int          err_count;
  int          checks;
  int          cycles;

  reconfig_status_recorder i_dut (
    .ref_clk             (ref_clk),
    .srst                (srst),
    .trigger             (trigger),
    .msm_state           (msm_state),
    .boot_addr           (boot_addr),
    .wd_enable           (wd_enable),
    .wd_timeout          (wd_timeout),
    .upgrade_shift_clock (shift_clk),
    .capture_pin         (capture),
    .capture_sel         (sel),
    .shift_data_in       (data_in),
    .shift_data_out      (shift_data_out),
    .cause_q             (cause_q),
    .record_done         (record_done)
  );

  shift_reader i_reader (
    .ref_clk        (ref_clk),
    .shift_data_out (shift_data_out),
    .shift_clk      (shift_clk),
    .capture        (capture),
    .sel            (sel),
    .data_in        (data_in)
  );

  // free-running 100 ns clock
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // hang guard, well above the ~6200 cycles the scenarios need
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #10;
  endtask

  // one-cycle strobe; winner must show one edge later
  task automatic fire(input logic [4:0] t, input logic [4:0] win);
    trigger = t;
    tick(1);
    trigger = 5'h00;
    check(32'(record_done), 32'h1);
    check(32'(cause_q), 32'(win));
    tick(1);
    check(32'(record_done), 32'h0);
  endtask

  task automatic t_reset();
    check({26'h0, cause_q, record_done}, 32'h0);
    i_reader.read_word(2'h1, w);
    check(w, 32'hFFFFFFFF);
    $display("done reset");
  endtask

  // each mode's layout, with fields chosen to expose a wrong layout
  task automatic t_views();
    boot_addr  = 24'hA5C3E1;
    wd_enable  = 1'b1;
    wd_timeout = 29'h1ABCDEF5;
    i_reader.read_word(2'h0, w);
    check(w, {2'b00, 6'h00, 24'hA5C3E1});
    msm_state = MSM_APP1;
    i_reader.read_word(2'h0, w);
    check(w, {2'b01, 1'b1, 29'h1ABCDEF5});
    msm_state = MSM_APP2;
    boot_addr = 24'h3C5A96;
    i_reader.read_word(2'h0, w);
    check(w, {2'b10, 6'h00, 24'h3C5A96});
    $display("done views");
  endtask

  // every source alone, then two ties, in factory so no history forms
  task automatic t_sources();
    msm_state = MSM_FACTORY;
    for (int i = 0; i < 5; i++)
      fire(5'h01 << i, 5'h01 << i);
    fire(5'h11, 5'h10);
    fire(5'h0C, 5'h08);
    i_reader.read_word(2'h3, w);
    check(w, 32'h00000008);
    i_reader.read_word(2'h1, w);
    check(w, 32'hFFFFFFFF);
    $display("done sources");
  endtask

  // two app exits build both records; a factory exit leaves them
  task automatic t_history();
    msm_state = MSM_APP1;
    boot_addr = 24'h123456;
    fire(5'h02, 5'h02);
    msm_state = MSM_APP2;
    boot_addr = 24'hFEDCBA;
    fire(5'h09, 5'h08);
    msm_state = MSM_FACTORY;
    fire(5'h10, 5'h10);
    i_reader.read_word(2'h1, w);
    check(w, {1'b0, 5'h08, 2'b10, 24'hFEDCBA});
    i_reader.read_word(2'h2, w);
    check(w, {1'b0, 5'h02, 2'b01, 24'h123456});
    $display("done history");
  endtask

  initial
  begin
    srst       = 1'b1;
    trigger    = 5'h00;
    msm_state  = MSM_FACTORY;
    boot_addr  = 24'h000000;
    wd_enable  = 1'b0;
    wd_timeout = 29'h0;
    tick(3);
    srst = 1'b0;
    tick(4);
    t_reset();
    t_views();
    t_sources();
    t_history();
    close_out();
  end
endmodule
